// ---- include/gpt_pkg.sv ----
// shared constants and types for the three general purpose timer/counters
package gpt_pkg;

    // -----------------------------------------------------------------
    // sizes and timing
    // -----------------------------------------------------------------
    localparam int unsigned GPT_UNITS        = 3;
    localparam int unsigned GPT_CNT_W        = 16;
    localparam int unsigned GPT_T2_IDX       = 2;
    localparam int unsigned GPT_EDGE_OSC     = 24; // oscillator periods to see one falling edge
    localparam int unsigned GPT_EDGE_MCS     = 2;  // machine cycles to see one falling edge
    localparam int unsigned GPT_OSC_PER_MC   = GPT_EDGE_OSC / GPT_EDGE_MCS;
    localparam int unsigned GPT_MC_CNT_W     = 8;

    // -----------------------------------------------------------------
    // count values
    // -----------------------------------------------------------------
    localparam logic [15:0] GPT_CNT_RST      = 16'h0000;
    localparam logic [15:0] GPT_CNT_MAX      = 16'hffff;
    localparam logic [15:0] GPT_CNT_ONE      = 16'h0001;
    localparam logic [7:0]  GPT_MC_ZERO      = 8'h00;
    localparam logic [7:0]  GPT_MC_ONE       = 8'h01;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        GPT_T2_PLAIN   = 2'b00,
        GPT_T2_CAPTURE = 2'b01,
        GPT_T2_RELOAD  = 2'b11,
        GPT_T2_OUTGEN  = 2'b10
    } gpt_t2_mode_t;

    typedef struct packed {
        logic run;
        logic counter_mode;
        logic irq_en;
    } gpt_unit_cfg_t;

    typedef struct packed {
        logic [7:0] count_high_byte;
        logic [7:0] count_low_byte;
    } gpt_count_t;

    typedef struct packed {
        gpt_t2_mode_t mode;
        logic         trig_en;
        logic         updown_en;
    } gpt_t2_cfg_t;

endpackage

// ---- rtl/gpt_edge_sample.sv ----
// once-per-machine-cycle sampler with falling transition detect
module gpt_edge_sample (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic tick_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      fall_out
);

    // -----------------------------------------------------------------
    // sampling
    // -----------------------------------------------------------------
    logic samp_q;
    logic fall_q;
    wire  fall_d = samp_q & ~pin_in; // high then low on consecutive samples

    // fall stands for one whole machine cycle, consumed at the next tick
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            samp_q <= 1'b0;
            fall_q <= 1'b0;
        end else if (tick_in) begin
            samp_q <= pin_in;
            fall_q <= fall_d;
        end
    end

    assign level_out = samp_q;
    assign fall_out  = fall_q;

endmodule

// ---- rtl/gpt_timers.sv ----
// three 16-bit timer/counters, the third with capture, reload and output modes

// What this block does
// - three independent 16-bit units, timer or counter
// - timer function counts every machine cycle
// - counter function counts pin falling transitions
// - pin sampled once per machine cycle
// - new count visible the following machine cycle
// - one edge takes two machine cycles
// - periodic interrupt requests from overflows
// - third unit always full 16-bit
// - third unit: plain, capture, reload, output
// - trigger pin captures, reloads, picks direction
module gpt_timers #(
    parameter int unsigned OSC_PER_MC = gpt_pkg::GPT_OSC_PER_MC
) (
    input  wire logic                                  mclk_in,
    input  wire logic                                  rst_in,
    input  wire logic                                  ext_count_in_0,
    input  wire logic                                  ext_count_in_1,
    input  wire logic                                  ext_count_in_2,
    input  wire logic                                  third_timer_trigger_in,
    input  wire gpt_pkg::gpt_unit_cfg_t [2:0]          unit_cfg_in,
    input  wire gpt_pkg::gpt_t2_cfg_t                  t2_cfg_in,
    input  wire logic [15:0]                           t2_reload_in,
    input  wire logic [2:0]                            flag_clear_in,
    output gpt_pkg::gpt_count_t [2:0]                  count_out,
    output logic [2:0]                                 ovf_flag_out,
    output logic [2:0]                                 irq_out,
    output logic [15:0]                                t2_capture_out,
    output logic                                       t2_toggle_out,
    output logic                                       mc_tick_out
);

    // -----------------------------------------------------------------
    // machine cycle timebase
    // -----------------------------------------------------------------
    localparam logic [7:0] MC_LAST = 8'(OSC_PER_MC - 1);

    logic [7:0] mc_cnt_q;
    logic       tick_q;
    wire        mc_wrap = (mc_cnt_q == MC_LAST);
    wire  [7:0] mc_cnt_d = mc_wrap ? gpt_pkg::GPT_MC_ZERO : mc_cnt_q + gpt_pkg::GPT_MC_ONE;

    // one-clock tick per machine cycle drives all sampling and counting
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            mc_cnt_q <= gpt_pkg::GPT_MC_ZERO;
            tick_q   <= 1'b0;
        end else begin
            mc_cnt_q <= mc_cnt_d;
            tick_q   <= mc_wrap;
        end
    end

    // -----------------------------------------------------------------
    // pin sampling, one sampler per unit and one for the trigger
    // -----------------------------------------------------------------
    wire  [2:0] pin_w = {ext_count_in_2, ext_count_in_1, ext_count_in_0};
    logic [2:0] fall_w;
    logic       trig_lvl_w;
    logic       trig_fall_w;

    gpt_edge_sample u_trig (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .tick_in   (tick_q),
        .pin_in    (third_timer_trigger_in),
        .level_out (trig_lvl_w),
        .fall_out  (trig_fall_w)
    );

    // -----------------------------------------------------------------
    // helper functions
    // -----------------------------------------------------------------
    // plain 16-bit step, wraps from all ones to zero
    function automatic logic [15:0] cnt_inc(input logic [15:0] v);
        return v + gpt_pkg::GPT_CNT_ONE;
    endfunction

    // third unit mode test, shared by every mode decode below
    function automatic logic t2_mode_is(input gpt_pkg::gpt_t2_mode_t cur,
                                        input gpt_pkg::gpt_t2_mode_t want);
        return (cur == want);
    endfunction

    // -----------------------------------------------------------------
    // per-unit count enable and plain 16-bit counting
    // -----------------------------------------------------------------
    // count_d holds every unit's next value, one register bank takes it
    gpt_pkg::gpt_count_t [2:0] count_q;
    gpt_pkg::gpt_count_t [2:0] count_d;
    logic [2:0]                inc_en;
    logic [2:0]                ovf_w;
    logic [15:0]               capture_q;
    logic                      toggle_q;

    genvar gi;
    generate
        for (gi = 0; gi < gpt_pkg::GPT_UNITS; gi++) begin : g_unit
            // samples on each machine cycle tick, fall stands one machine cycle
            gpt_edge_sample u_pin (
                .mclk_in   (mclk_in),
                .rst_in    (rst_in),
                .tick_in   (tick_q),
                .pin_in    (pin_w[gi]),
                .level_out (),
                .fall_out  (fall_w[gi])
            );

            // timer counts each machine cycle, counter only on a seen edge
            assign inc_en[gi] = tick_q & unit_cfg_in[gi].run
                              & (unit_cfg_in[gi].counter_mode ? fall_w[gi] : 1'b1);

            if (gi != gpt_pkg::GPT_T2_IDX) begin : g_basic
                assign ovf_w[gi] = inc_en[gi] & (count_q[gi] == gpt_pkg::GPT_CNT_MAX);

                // count applied at the tick after detection: visible next cycle
                assign count_d[gi] = inc_en[gi] ? cnt_inc(count_q[gi])
                                                : count_q[gi];
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // third unit: mode decode and next value
    // -----------------------------------------------------------------
    localparam int unsigned T2 = gpt_pkg::GPT_T2_IDX;

    wire [15:0] t2_cnt       = count_q[T2];
    // mode decode
    wire        t2_is_cap    = t2_mode_is(t2_cfg_in.mode, gpt_pkg::GPT_T2_CAPTURE);
    wire        t2_is_rld    = t2_mode_is(t2_cfg_in.mode, gpt_pkg::GPT_T2_RELOAD);
    wire        t2_is_out    = t2_mode_is(t2_cfg_in.mode, gpt_pkg::GPT_T2_OUTGEN);
    wire        t2_use_rld   = t2_is_rld | t2_is_out;
    // trigger level picks direction: high counts up, low counts down
    wire        t2_down      = t2_is_rld & t2_cfg_in.updown_en & ~trig_lvl_w;
    wire        t2_trig      = tick_q & trig_fall_w & t2_cfg_in.trig_en;
    wire        t2_force_rld = t2_trig & t2_is_rld & ~t2_cfg_in.updown_en;
    // counting bounds: all ones going up, reload value going down
    wire        t2_hit_top   = (t2_cnt == gpt_pkg::GPT_CNT_MAX);
    wire        t2_hit_bot   = (t2_cnt == t2_reload_in);
    wire        t2_step      = inc_en[T2];
    // full 16-bit roll in either direction, never a narrower mode
    wire        t2_ovf       = t2_step & (t2_down ? t2_hit_bot : t2_hit_top);
    // candidate next values
    wire [15:0] t2_inc       = cnt_inc(t2_cnt);
    wire [15:0] t2_dec       = t2_cnt - gpt_pkg::GPT_CNT_ONE;
    wire [15:0] t2_roll      = t2_down ? gpt_pkg::GPT_CNT_MAX : t2_reload_in;
    wire [15:0] t2_stepped   = (t2_ovf & t2_use_rld) ? t2_roll : (t2_down ? t2_dec : t2_inc);
    wire [15:0] t2_next      = t2_force_rld ? t2_reload_in
                             : (t2_step ? t2_stepped : t2_cnt);

    assign ovf_w[T2]   = t2_ovf;
    assign count_d[T2] = t2_next;

    // all three counts load their next value on every clock
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= {gpt_pkg::GPT_UNITS{gpt_pkg::GPT_CNT_RST}};
        end else begin
            count_q <= count_d;
        end
    end

    // third unit capture register and output toggle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            capture_q <= gpt_pkg::GPT_CNT_RST;
            toggle_q  <= 1'b0;
        end else begin
            if (t2_trig & t2_is_cap) begin
                capture_q <= t2_cnt;
            end
            if (t2_ovf & t2_is_out) begin
                toggle_q <= ~toggle_q;
            end
        end
    end

    // -----------------------------------------------------------------
    // overflow flags and interrupt requests
    // -----------------------------------------------------------------
    logic [2:0]  flag_q;
    logic [2:0]  irq_q;
    logic [2:0]  irq_en_w;
    logic [2:0]  flag_d;

    generate
        for (gi = 0; gi < gpt_pkg::GPT_UNITS; gi++) begin : g_flag
            assign irq_en_w[gi] = unit_cfg_in[gi].irq_en;
        end
    endgenerate

    // a rollover in the clearing cycle still sets the flag
    assign flag_d = ovf_w | (flag_q & ~flag_clear_in);

    // flag is sticky, request follows flag while enabled
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_q <= 3'h0;
            irq_q  <= 3'h0;
        end else begin
            flag_q <= flag_d;
            irq_q  <= flag_d & irq_en_w;
        end
    end

    // -----------------------------------------------------------------
    // outputs, all from flip-flops
    // -----------------------------------------------------------------
    assign count_out      = count_q;
    assign ovf_flag_out   = flag_q;
    assign irq_out        = irq_q;
    assign t2_capture_out = capture_q;
    assign t2_toggle_out  = toggle_q;
    assign mc_tick_out    = tick_q;

endmodule

// ---- dv/gpt_timers_monitor.sv ----
// concurrent checks on the timer/counter ports
module gpt_timers_monitor #(
    parameter int unsigned OSC_PER_MC = 12
) (
    input wire logic                         mclk_in,
    input wire logic                         rst_in,
    input wire gpt_pkg::gpt_unit_cfg_t [2:0] unit_cfg_in,
    input wire gpt_pkg::gpt_t2_cfg_t         t2_cfg_in,
    input wire logic [2:0]                   flag_clear_in,
    input wire gpt_pkg::gpt_count_t [2:0]    count_out,
    input wire logic [2:0]                   ovf_flag_out,
    input wire logic [2:0]                   irq_out,
    input wire logic                         mc_tick_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TP1 = OSC_PER_MC - 1;
    // one clock domain for every check
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    a_tick_period: assert property (mc_tick_out |=> !mc_tick_out ##TP1 mc_tick_out)
        else $error("machine cycle tick spacing wrong");
    a_count_on_tick: assert property ($changed(count_out) |-> $past(mc_tick_out))
        else $error("count moved outside a machine cycle");
    a_timer_step: assert property (mc_tick_out && unit_cfg_in[0].run
        && !unit_cfg_in[0].counter_mode |=> count_out[0] == $past(count_out[0]) + 16'h0001)
        else $error("timer did not step by one");
    a_run_freeze: assert property (mc_tick_out && !unit_cfg_in[1].run |=> $stable(count_out[1]))
        else $error("stopped unit moved");
    a_event_step: assert property ($changed(count_out[1])
        |-> count_out[1] == $past(count_out[1]) + 16'h0001)
        else $error("event count jumped");
    a_wrap_flag: assert property ($past(count_out[2]) == 16'hffff
        && $past(mc_tick_out) && $past(unit_cfg_in[2].run)
        && !$past(unit_cfg_in[2].counter_mode) && !$past(t2_cfg_in.updown_en)
        |-> ovf_flag_out[2])
        else $error("rollover left flag clear");
    a_flag_sticky: assert property (ovf_flag_out[2] && !flag_clear_in[2] |=> ovf_flag_out[2])
        else $error("flag dropped without clear");
    a_flag_clear: assert property (ovf_flag_out[2] && flag_clear_in[2] && !mc_tick_out
        |=> !ovf_flag_out[2])
        else $error("flag clear ignored");
    a_irq_raise: assert property ($rose(ovf_flag_out[2]) && unit_cfg_in[2].irq_en
        |-> ##[0:1] irq_out[2])
        else $error("enabled interrupt not raised");
    c_wrap: cover property ($rose(ovf_flag_out[2]));
    c_event: cover property ($changed(count_out[1]));
    c_timer: cover property ($changed(count_out[0]));
endmodule
bind gpt_timers gpt_timers_monitor #(.OSC_PER_MC(OSC_PER_MC)) i_gpt_timers_monitor (
    .mclk_in(mclk_in), .rst_in(rst_in), .unit_cfg_in(unit_cfg_in), .t2_cfg_in(t2_cfg_in),
    .flag_clear_in(flag_clear_in), .count_out(count_out), .ovf_flag_out(ovf_flag_out),
    .irq_out(irq_out), .mc_tick_out(mc_tick_out));

// ---- dv/gpt_pin_src.sv ----
// event source model driving one count pin at the fastest legal rate
module gpt_pin_src (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic tick_in,
    input  wire logic en_in,
    output logic      pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // each level held one full machine cycle, idle high
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= 1'b1;
        end else if (tick_in) begin
            pin_out <= en_in ? ~pin_out : 1'b1;
        end
    end
endmodule

// ---- dv/gpt_timers_tb.sv ----
// self-checking bench for the timer/counters
module gpt_timers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned MC = 2;
    logic                         mclk_in = 1'b0;
    logic                         rst_in = 1'b1;
    logic                         trig = 1'b1;
    logic [2:0]                   pin;
    logic [2:0]                   src_en = 3'h0;
    logic [2:0]                   clr = 3'h0;
    gpt_pkg::gpt_unit_cfg_t [2:0] cfg = 9'h000;
    gpt_pkg::gpt_t2_cfg_t         t2c = 4'h0;
    logic [15:0]                  reload = 16'h0000;
    logic [15:0]                  cap;
    logic [15:0]                  c1;
    logic [15:0]                  falls = 16'h0000;
    gpt_pkg::gpt_count_t [2:0]    cnt;
    logic [2:0]                   flag;
    logic [2:0]                   irq;
    logic                         tog;
    logic                         tick;
    int                           bad_count = 0;
    int                           comparisons = 0;
    always #20 mclk_in = ~mclk_in;
    // counts pin falls made by the source on unit 1
    always @(negedge pin[1]) falls = falls + 16'h0001;
    for (genvar g = 0; g < 3; g++) begin : g_src
        gpt_pin_src i_gpt_pin_src (.mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick),
            .en_in(src_en[g]), .pin_out(pin[g]));
    end
    gpt_timers #(.OSC_PER_MC(MC)) i_gpt_timers (.mclk_in(mclk_in), .rst_in(rst_in),
        .ext_count_in_0(pin[0]), .ext_count_in_1(pin[1]), .ext_count_in_2(pin[2]),
        .third_timer_trigger_in(trig), .unit_cfg_in(cfg), .t2_cfg_in(t2c),
        .t2_reload_in(reload), .flag_clear_in(clr), .count_out(cnt), .ovf_flag_out(flag),
        .irq_out(irq), .t2_capture_out(cap), .t2_toggle_out(tog), .mc_tick_out(tick));
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #5;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task t_timer;
        chk("reset state", 16'h0000, cnt[0] | cnt[1] | cnt[2] | {flag, irq});
        cfg[0].run = 1'b1;
        step(4);
        c1 = cnt[0];
        step(10 * MC);
        chk("timer count", c1 + 16'h000a, cnt[0]);
    endtask
    task t_counter;
        cfg[0] = 3'h6;
        cfg[1] = 3'h6;
        step(4);
        c1 = cnt[0];
        src_en[1] = 1'b1;
        step(20 * MC);
        src_en[1] = 1'b0;
        step(6 * MC);
        chk("event count", falls, cnt[1]);
        chk("idle pin count", c1, cnt[0]);
    endtask
    task t_wrap;
        cfg[2] = 3'h5;
        t2c = {gpt_pkg::GPT_T2_RELOAD, 1'b1, 1'b0};
        reload = 16'hfffd;
        step(3 * MC);
        trig = 1'b0;
        step(10 * MC);
        chk("wrap flag irq", 16'h0003, {14'h0000, flag[2], irq[2]});
        chk("reload floor", 16'h0001, {15'h0000, cnt[2] >= 16'hfffd});
        t2c.mode = gpt_pkg::GPT_T2_OUTGEN;
        step(MC);
        c1 = {15'h0000, tog};
        step(3 * MC);
        chk("toggle", c1 ^ 16'h0001, {15'h0000, tog});
        cfg[2].run = 1'b0;
        step(MC);
        clr = 3'h4;
        step(1);
        clr = 3'h0;
        step(2);
        chk("flag cleared", 16'h0000, {14'h0000, flag[2], irq[2]});
    endtask
    task t_down_capture;
        reload = 16'h0000;
        t2c = {gpt_pkg::GPT_T2_RELOAD, 1'b0, 1'b1};
        cfg[2].run = 1'b1;
        step(2 * MC);
        c1 = cnt[2];
        step(4 * MC);
        chk("down count", c1 - 16'h0004, cnt[2]);
        t2c = {gpt_pkg::GPT_T2_CAPTURE, 1'b1, 1'b0};
        trig = 1'b1;
        step(2 * MC);
        trig = 1'b0;
        step(3 * MC);
        chk("capture age", 16'h0001, {15'h0000, (cnt[2] - cap) <= 16'h0004});
    endtask
    task t_unit2_events;
        t2c = {gpt_pkg::GPT_T2_PLAIN, 1'b0, 1'b0};
        cfg[2] = 3'h6;
        step(4);
        c1 = cnt[2];
        src_en[2] = 1'b1;
        step(8 * MC);
        src_en[2] = 1'b0;
        step(6 * MC);
        chk("unit 2 event count", c1 + 16'h0004, cnt[2]);
    endtask
    initial begin
        step(5);
        rst_in = 1'b0;
        t_timer;
        t_counter;
        t_wrap;
        t_down_capture;
        t_unit2_events;
        report_and_stop;
    end
    // hang guard well beyond the fewer than two hundred cycles the tests take
    initial begin
        #200000;
        bad_count++;
        report_and_stop;
    end
endmodule
